//--- rsrs_pkg.sv
// constants, types and helpers shared by the rolling shutter row sequencer
// Functional notes
// RL1: T0 holds both transfer gates and reset on
// RL2: T1 drops first transfer gate, keeps rest
// RL3: T2 drops second gate one row later
// RL4: T3 releases reset before charge transfer
// RL5: T4 first gate, diffusion, row select together
// RL6: T5 drops select, diffusion; reset back on
// RL7: second row: release reset, T6 readout
// RL8: receiver discards dummy pixel values
// RL9: dark pixels read out for black level
// RL10: bit 6 of capture register picks mode
// RL11: continuous capture mode after reset
// RL12: continuous: staggered integration during readout
// RL13: continuous: next frame starts without trigger
// RL14: encoding off: only pixel words output
// RL15: stream bit 5 inserts in-band markers; code inserts them only in continuous mode
// RL16: frame start, row start, end patterns
// RL17: marker words one per clock, adjacent
// RL18: receiver syncs on markers or valids
// RL19: single mode starts on sync, waits
// RL20: row period vcw+shs+shr+19 clocks
// RL21: continuous frame is vrd+1 rows
package rsrs_pkg;

   localparam int PIX_W      = 10;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W     = PIX_W + 2;
   localparam int CTRL_W     = 8;
   localparam int CNT_W      = 13;

   localparam int CAP_MODE_BIT   = 6;
   localparam int STREAM_ENC_BIT = 5;
   localparam logic [CTRL_W-1:0] CAP_CTRL_RST    = 8'h00;
   localparam logic [CTRL_W-1:0] STREAM_CTRL_RST = 8'h00;
   localparam logic              CAP_CONTINUOUS  = 1'b0;

   localparam logic [CNT_W-1:0] ROW_OVERHEAD = 13'h0013;
   localparam logic [CNT_W-1:0] COL_SHUT_A   = 13'h0000;
   localparam logic [CNT_W-1:0] COL_SHUT_B   = 13'h0001;
   localparam logic [CNT_W-1:0] COL_RST_REL  = 13'h0002;
   localparam logic [CNT_W-1:0] COL_MARK     = 13'h0003;
   localparam logic [CNT_W-1:0] MARK_LEN     = 13'h0004;
   localparam logic [CNT_W-1:0] COL_PIX_BASE = 13'h0007;
   localparam logic [CNT_W-1:0] DUMMY_ROWS   = 13'h0001;
   localparam logic [CNT_W-1:0] DARK_ROWS    = 13'h0002;

   localparam logic [PIX_W-1:0] MARK_HI = 10'h3ff;
   localparam logic [PIX_W-1:0] MARK_LO = 10'h000;

   typedef enum logic [2:0] {
      ST_REST = 3'b000,
      ST_T0   = 3'b001,
      ST_T1   = 3'b010,
      ST_T2   = 3'b011,
      ST_T3   = 3'b100,
      ST_T4   = 3'b101,
      ST_T5   = 3'b110,
      ST_T6   = 3'b111
   } rsrs_step_e;

   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_RUN  = 1'b1
   } rsrs_seq_e;

   typedef enum logic [1:0] {
      MK_SOF = 2'b00,
      MK_ROW = 2'b01,
      MK_EOF = 2'b10
   } rsrs_mark_e;

   // word idx of a marker, most significant group first
   function automatic logic [PIX_W-1:0] marker_word(input rsrs_mark_e kind, input logic [1:0] idx);
      logic [PIX_W-1:0] w;
      w = MARK_LO;
      case (kind)
         MK_SOF:  w = MARK_HI;
         MK_ROW:  w = idx[1] ? MARK_LO : MARK_HI;
         default: w = MARK_LO;
      endcase
      return w;
   endfunction : marker_word

   // gate vector {reset, tx1, tx2, diffusion, row select}
   function automatic logic [4:0] gates_of(input rsrs_step_e st);
      logic [4:0] g;
      g = 5'h10;
      unique case (st)
         ST_REST: g = 5'h10;
         ST_T0:   g = 5'h1c;
         ST_T1:   g = 5'h14;
         ST_T2:   g = 5'h10;
         ST_T3:   g = 5'h00;
         ST_T4:   g = 5'h0b;
         ST_T5:   g = 5'h10;
         ST_T6:   g = 5'h07;
      endcase
      return g;
   endfunction : gates_of

endpackage : rsrs_pkg

//--- rsrs_fifo.sv
// small flip-flop fifo between the sequencer and the pixel port
`timescale 1ns/1ps
`default_nettype none
module rsrs_fifo #(
   parameter int W = 12,
   parameter int D = 4
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0]   cnt_ff;
   logic          do_wr;
   logic          do_rd;

   assign in_ready_o  = (cnt_ff != (AW+1)'(D));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o  = mem_ff[rd_ff];
   assign do_wr       = in_valid_i & in_ready_o;
   assign do_rd       = out_valid_o & out_ready_i;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(D-1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   always_ff @(posedge core_clk_i) begin
      if (do_wr) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_wr) begin
            wr_ff <= ptr_inc(wr_ff);
         end
         if (do_rd) begin
            rd_ff <= ptr_inc(rd_ff);
         end
         if (do_wr & ~do_rd) begin
            cnt_ff <= cnt_ff + (AW+1)'(1);
         end else if (do_rd & ~do_wr) begin
            cnt_ff <= cnt_ff - (AW+1)'(1);
         end
      end
   end
endmodule : rsrs_fifo
`default_nettype wire

//--- rsrs_row_sequencer.sv
// rolling shutter capture and readout sequencer with pixel stream output
`timescale 1ns/1ps
`default_nettype none
module rsrs_row_sequencer (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_b_i,
   // capture mode control register write
   input  wire logic                          cap_wr_i,
   input  wire logic [rsrs_pkg::CTRL_W-1:0]   cap_data_i,
   output logic [rsrs_pkg::CTRL_W-1:0]        cap_ctrl_o,
   // pixel stream control register write
   input  wire logic                          stream_wr_i,
   input  wire logic [rsrs_pkg::CTRL_W-1:0]   stream_data_i,
   output logic [rsrs_pkg::CTRL_W-1:0]        stream_ctrl_o,
   // frame geometry and timing settings
   input  wire logic [11:0]                   vcw_i,
   input  wire logic [7:0]                    shs_i,
   input  wire logic [7:0]                    shr_i,
   input  wire logic [11:0]                   vrd_i,
   input  wire logic [11:0]                   cint_i,
   input  wire logic                          sync_i,
   input  wire logic [rsrs_pkg::PIX_W-1:0]    adc_data_i,
   // pixel gate controls for the addressed row
   output logic                               gate_rst_o,
   output logic                               gate_tx1_o,
   output logic                               gate_tx2_o,
   output logic                               gate_fd_o,
   output logic                               gate_rsel_o,
   output logic [rsrs_pkg::CNT_W-1:0]         gate_row_o,
   // pixel stream
   output logic                               pix_valid_o,
   input  wire logic                          pix_ready_i,
   output logic [rsrs_pkg::PIX_W-1:0]         pix_data_o,
   output logic                               pix_dark_o,
   output logic                               pix_dummy_o,
   output logic                               frame_valid_o,
   output logic                               line_valid_o,
   output logic                               busy_o
);
   import rsrs_pkg::*;

   // sample-and-hold span shared by the row length and the pixel slot start
   function automatic logic [CNT_W-1:0] hold_span(input logic [7:0] a, input logic [7:0] b);
      return CNT_W'(a) + CNT_W'(b);
   endfunction : hold_span

   // true while col lies in the len columns that start at base
   function automatic logic in_span(input logic [CNT_W-1:0] col, input logic [CNT_W-1:0] base,
                                    input logic [CNT_W-1:0] len);
      return (col >= base) && ((col - base) < len);
   endfunction : in_span

   logic [CTRL_W-1:0] cap_ctrl_ff;
   logic [CTRL_W-1:0] stream_ctrl_ff;
   rsrs_seq_e         seq_ff;
   logic [CNT_W-1:0]  col_ff;
   logic [CNT_W-1:0]  lin_ff;
   rsrs_step_e        step_ff;
   logic [4:0]        gates_ff;
   logic [CNT_W-1:0]  row_ff;
   logic              frame_ff;
   logic              line_ff;
   logic              mode_ff;
   logic              sync_q_ff;
   logic [11:0]       vcw_ff;
   logic [7:0]        shs_ff;
   logic [7:0]        shr_ff;
   logic [11:0]       vrd_ff;
   logic [11:0]       cint_ff;

   logic              continuous;
   logic              enc_on;
   logic              run;
   logic              cap_cont;
   logic              sync_rise;
   logic              frame_load;
   logic [CNT_W-1:0]  int_rows;
   logic [CNT_W-1:0]  trow;
   logic [CNT_W-1:0]  col_last;
   logic [CNT_W-1:0]  pix_start;
   logic [CNT_W-1:0]  pix_end;
   logic [CNT_W-1:0]  vrd_w;
   logic [CNT_W-1:0]  lead;
   logic [CNT_W-1:0]  lin_last;
   logic [CNT_W-1:0]  read_row;
   logic [CNT_W-1:0]  shut_row;
   logic              read_act;
   logic              shut_act;
   logic              row_end;
   logic              frame_end;
   rsrs_step_e        nxt_step;
   logic [CNT_W-1:0]  nxt_row;

   logic              mark_slot;
   logic              pix_slot;
   logic              eof_slot;
   logic              push_req;
   logic [FIFO_W-1:0] push_data;
   logic              fifo_in_ready;
   logic [FIFO_W-1:0] fifo_out;
   logic              stall;
   logic [CNT_W-1:0]  mark_off;
   logic [CNT_W-1:0]  eof_off;

   // control registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cap_ctrl_ff <= CAP_CTRL_RST; // RL11
      end else if (cap_wr_i) begin
         cap_ctrl_ff <= cap_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stream_ctrl_ff <= STREAM_CTRL_RST;
      end else if (stream_wr_i) begin
         stream_ctrl_ff <= stream_data_i;
      end
   end

   assign cap_ctrl_o    = cap_ctrl_ff;
   assign stream_ctrl_o = stream_ctrl_ff;
   assign cap_cont      = (cap_ctrl_ff[CAP_MODE_BIT] == CAP_CONTINUOUS); // RL10
   assign continuous    = (mode_ff == CAP_CONTINUOUS);
   assign enc_on        = stream_ctrl_ff[STREAM_ENC_BIT] & continuous; // RL15
   assign run           = (seq_ff == SEQ_RUN);
   assign sync_rise     = sync_i & ~sync_q_ff;

   // mode and timing are taken while idle and at each frame end, so a write
   // in mid-frame waits for the frame to finish instead of tearing it apart
   assign frame_load = ~run | (~stall & frame_end);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_ff <= CAP_CTRL_RST[CAP_MODE_BIT]; // RL11
         vcw_ff  <= '0;
         shs_ff  <= '0;
         shr_ff  <= '0;
         vrd_ff  <= '0;
         cint_ff <= '0;
      end else if (frame_load) begin
         mode_ff <= cap_ctrl_ff[CAP_MODE_BIT]; // RL10
         vcw_ff  <= vcw_i;
         shs_ff  <= shs_i;
         shr_ff  <= shr_i;
         vrd_ff  <= vrd_i;
         cint_ff <= cint_i;
      end
   end

   // a held sync must not start a second frame, only a fresh rising edge does
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_q_ff <= 1'b0;
      end else begin
         sync_q_ff <= sync_i;
      end
   end

   // row timing
   assign trow      = CNT_W'(vcw_ff) + hold_span(shs_ff, shr_ff) + ROW_OVERHEAD; // RL20
   assign col_last  = trow - CNT_W'(1);
   assign pix_start = COL_PIX_BASE + hold_span(shs_ff, shr_ff);
   assign pix_end   = pix_start + CNT_W'(vcw_ff);
   assign vrd_w     = CNT_W'(vrd_ff);
   assign int_rows  = CNT_W'(cint_ff) + CNT_W'(1);
   // integration cannot exceed the frame in continuous mode, so the lead is clamped
   assign lead      = (CNT_W'(cint_ff) >= vrd_w) ? vrd_w : int_rows;
   assign lin_last  = continuous ? vrd_w : vrd_w + int_rows;
   assign row_end   = (col_ff == col_last);
   assign frame_end = row_end & (lin_ff == lin_last);

   // which row is integrating and which is being read
   always_comb begin
      read_row = '0;
      shut_row = '0;
      read_act = 1'b0;
      shut_act = 1'b0;
      if (run) begin
         if (continuous) begin
            // shutter pointer runs ahead of the read pointer, wrapping in the frame
            read_act = 1'b1; // RL12
            shut_act = 1'b1;
            read_row = lin_ff;
            if ((lin_ff + lead) > vrd_w) begin
               shut_row = lin_ff + lead - vrd_w - CNT_W'(1);
            end else begin
               shut_row = lin_ff + lead;
            end
         end else begin
            shut_act = (lin_ff <= vrd_w);
            shut_row = lin_ff;
            read_act = (lin_ff >= int_rows);
            read_row = lin_ff - int_rows;
         end
      end
   end

   // gate step decode: two shutter slots, then the read row
   always_comb begin
      nxt_step = ST_REST;
      nxt_row  = read_row;
      if (col_ff == COL_SHUT_A) begin
         nxt_row = shut_row;
         if (shut_act & ~shut_row[0]) begin
            nxt_step = ST_T0; // RL1
         end
      end else if (col_ff == COL_SHUT_B) begin
         nxt_row = shut_row;
         if (shut_act) begin
            // odd row one full row period after the even row's release
            nxt_step = shut_row[0] ? ST_T2 : ST_T1; // RL2 RL3
         end
      end else if (read_act) begin
         if (col_ff == COL_RST_REL) begin
            nxt_step = ST_T3; // RL4 RL7
         end else if (row_end) begin
            nxt_step = ST_T5; // RL6
         end else begin
            nxt_step = read_row[0] ? ST_T6 : ST_T4; // RL5 RL7
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         step_ff  <= ST_REST;
         gates_ff <= 5'h10;
         row_ff   <= '0;
      end else if (!stall) begin
         step_ff  <= nxt_step;
         gates_ff <= gates_of(nxt_step);
         row_ff   <= nxt_row;
      end
   end

   assign gate_rst_o  = gates_ff[4];
   assign gate_tx1_o  = gates_ff[3];
   assign gate_tx2_o  = gates_ff[2];
   assign gate_fd_o   = gates_ff[1];
   assign gate_rsel_o = gates_ff[0];
   assign gate_row_o  = row_ff;

   // stream slots within the read row
   assign mark_off  = col_ff - COL_MARK;
   assign eof_off   = col_ff - pix_end;
   assign mark_slot = read_act & enc_on & in_span(col_ff, COL_MARK, MARK_LEN); // RL14 RL16
   assign pix_slot  = read_act & (col_ff >= pix_start) & (col_ff < pix_end); // RL9
   assign eof_slot  = read_act & enc_on & (read_row == vrd_w) & in_span(col_ff, pix_end, MARK_LEN);
   assign push_req  = mark_slot | pix_slot | eof_slot;

   always_comb begin
      push_data = '0;
      if (mark_slot) begin
         // marker words sit ahead of the row's pixels, separated from them by the shs+shr hold span
         push_data = {2'b00, marker_word((read_row == '0) ? MK_SOF : MK_ROW, mark_off[1:0])}; // RL16 RL17
      end else if (eof_slot) begin
         push_data = {2'b00, marker_word(MK_EOF, eof_off[1:0])}; // RL16 RL17
      end else if (pix_slot) begin
         push_data = {read_row < DUMMY_ROWS,
                      (read_row >= DUMMY_ROWS) & (read_row < (DUMMY_ROWS + DARK_ROWS)),
                      adc_data_i}; // RL8 RL9
      end
   end

   // a full fifo freezes the whole sequence rather than drop a word
   assign stall = push_req & ~fifo_in_ready;

   // sequence state
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seq_ff <= SEQ_IDLE;
      end else begin
         unique case (seq_ff)
            SEQ_IDLE: begin
               if (cap_cont | sync_rise) begin
                  seq_ff <= SEQ_RUN; // RL13 RL19
               end
            end
            SEQ_RUN: begin
               // a switch to single frame takes effect at the frame boundary
               if (!stall & frame_end & (~continuous | ~cap_cont)) begin
                  seq_ff <= SEQ_IDLE; // RL19
               end
            end
         endcase
      end
   end

   // column and row counters
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         col_ff <= '0;
         lin_ff <= '0;
      end else if (!run) begin
         col_ff <= '0;
         lin_ff <= '0;
      end else if (!stall) begin
         if (row_end) begin
            col_ff <= '0;
            if (frame_end) begin
               lin_ff <= '0; // RL13 RL21
            end else begin
               lin_ff <= lin_ff + CNT_W'(1);
            end
         end else begin
            col_ff <= col_ff + CNT_W'(1);
         end
      end
   end

   // frame and line valid levels
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frame_ff <= 1'b0;
         line_ff  <= 1'b0;
      end else if (!stall) begin
         frame_ff <= read_act;
         line_ff  <= pix_slot; // RL18
      end
   end

   assign frame_valid_o = frame_ff;
   assign line_valid_o  = line_ff;
   assign busy_o        = run;

   rsrs_fifo #(
      .W (FIFO_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push_req),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_data),
      .out_valid_o (pix_valid_o),
      .out_ready_i (pix_ready_i),
      .out_data_o  (fifo_out)
   );

   assign pix_data_o  = fifo_out[PIX_W-1:0];
   assign pix_dark_o  = fifo_out[PIX_W];
   assign pix_dummy_o = fifo_out[PIX_W+1];

endmodule : rsrs_row_sequencer
`default_nettype wire

//--- rsrs_chk_asserts.sv
// port-level assertions for the rolling shutter row sequencer
`timescale 1ns/1ps
`default_nettype none
module rsrs_chk (
   input wire logic                        core_clk_i,
   input wire logic                        rst_b_i,
   input wire logic                        cap_wr_i,
   input wire logic [rsrs_pkg::CTRL_W-1:0] cap_data_i,
   input wire logic [rsrs_pkg::CTRL_W-1:0] cap_ctrl_o,
   input wire logic                        stream_wr_i,
   input wire logic [rsrs_pkg::CTRL_W-1:0] stream_data_i,
   input wire logic [rsrs_pkg::CTRL_W-1:0] stream_ctrl_o,
   input wire logic                        sync_i,
   input wire logic                        gate_rst_o,
   input wire logic                        gate_tx1_o,
   input wire logic                        gate_tx2_o,
   input wire logic                        gate_fd_o,
   input wire logic                        gate_rsel_o,
   input wire logic                        pix_valid_o,
   input wire logic                        pix_ready_i,
   input wire logic [rsrs_pkg::PIX_W-1:0]  pix_data_o,
   input wire logic                        busy_o
);
   import rsrs_pkg::*;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_both_tx_rst: assert property (gate_tx1_o && gate_tx2_o |-> gate_rst_o && !gate_fd_o && !gate_rsel_o)
      else $error("both transfer gates on without reset");
   a_tx1_drop: assert property ($fell(gate_tx1_o) && !$past(gate_rsel_o) |-> gate_rst_o && gate_tx2_o)
      else $error("first gate release lost reset or second gate");
   a_rel_before_rd: assert property ($rose(gate_rsel_o) |-> !$past(gate_rst_o) && !$past(gate_tx1_o))
      else $error("readout began without reset released");
   a_read_gates: assert property (gate_rsel_o |-> gate_fd_o && !gate_rst_o && (gate_tx1_o != gate_tx2_o))
      else $error("readout gate set wrong");
   a_fd_with_sel: assert property (gate_fd_o |-> gate_rsel_o)
      else $error("diffusion gate on outside readout");
   a_read_end: assert property ($fell(gate_rsel_o) |-> gate_rst_o && !gate_fd_o && !gate_tx1_o && !gate_tx2_o)
      else $error("readout end did not return to reset");
   a_cap_write: assert property (cap_wr_i |=> cap_ctrl_o == $past(cap_data_i))
      else $error("capture register write lost");
   a_enc_write: assert property (stream_wr_i ##1 !stream_wr_i |-> stream_ctrl_o == $past(stream_data_i))
      else $error("stream register write lost");
   a_single_waits: assert property (cap_ctrl_o[CAP_MODE_BIT] && !busy_o && !sync_i && !cap_wr_i |=> !busy_o)
      else $error("single mode started without sync");
   a_pix_hold: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o))
      else $error("pixel word dropped while stalled");

   c_readout: cover property ($rose(gate_rsel_o));
   c_idle: cover property ($fell(busy_o));
   c_stall: cover property ((pix_valid_o && !pix_ready_i) [*2]);
endmodule : rsrs_chk
`default_nettype wire

//--- rsrs_pix_sink.sv
// stream consumer standing in for the downstream video processor
`timescale 1ns/1ps
`default_nettype none
module rsrs_pix_sink (
   input wire logic core_clk_i,
   input wire logic slow_i,
   output logic     pix_ready_o
);
   int ps = 32'h648818df;
   initial pix_ready_o = 1'b0;
   // slow mode accepts one word in four so the fifo fills and stalls the sequencer
   always @(posedge core_clk_i) begin
      #1 pix_ready_o = slow_i ? ({$random(ps)} % 4 == 0) : 1'b1;
   end
endmodule : rsrs_pix_sink
`default_nettype wire

//--- tb.sv
// self-checking bench for the rolling shutter row sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rsrs_pkg::*;
   typedef struct packed {logic [PIX_W-1:0] d; logic dk; logic dm; logic fl;} rsrs_exp_s;
   localparam int VCW = 4;
   localparam int VRD = 3;
   logic core_clk_i, rst_b_i, cap_wr_i, stream_wr_i, sync_i, slow, pix_ready_i;
   logic [CTRL_W-1:0] cap_data_i, cap_ctrl_o, stream_data_i, stream_ctrl_o;
   logic [11:0] vcw_i, vrd_i, cint_i;
   logic [7:0] shs_i, shr_i;
   logic [PIX_W-1:0] adc_data_i, pix_data_o, pix;
   logic gate_rst_o, gate_tx1_o, gate_tx2_o, gate_fd_o, gate_rsel_o, rsel_q, meas;
   logic pix_valid_o, pix_dark_o, pix_dummy_o, frame_valid_o, line_valid_o, busy_o;
   logic [CNT_W-1:0] gate_row_o;
   rsrs_exp_s q[$];
   rsrs_exp_s e;
   int seed = 32'h648818df;
   int error_cnt, comparisons, n, cyc, last, rises, fv_cnt, lv_cnt;

   rsrs_row_sequencer rsrs_row_sequencer_inst (.*);
   rsrs_pix_sink rsrs_pix_sink_inst (.core_clk_i(core_clk_i), .slow_i(slow), .pix_ready_o(pix_ready_i));

   always #12.5 core_clk_i = ~core_clk_i;

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      comparisons++;
      if (ex !== sn) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, ex, sn);
      end
   endtask : chk

   task automatic summarize;
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic push_row(input int r, input logic enc);
      for (int i = 0; i < 4; i++)
         if (enc)
            q.push_back('{(r == 0 || i < 2) ? 10'h3ff : 10'h000, 1'b0, 1'b0, 1'b0});
      for (int i = 0; i < VCW; i++)
         q.push_back('{pix, 1'(r == 1 || r == 2), 1'(r == 0), 1'b1});
      for (int i = 0; i < 4; i++)
         if (enc && r == VRD)
            q.push_back('{10'h000, 1'b0, 1'b0, 1'b0});
   endtask : push_row

   // stream monitor: each accepted word retires the oldest note; sampled mid-cycle,
   // where the word that the coming edge takes is settled
   always @(negedge core_clk_i) begin
      if (rst_b_i === 1'b1 && pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
         if (q.size() == 0) begin
            chk("extra word", 32'h0, 32'h1);
         end else begin
            e = q.pop_front();
            chk("pix_data", 32'(e.d), 32'(pix_data_o));
            if (e.fl) begin
               chk("pix_dark", 32'(e.dk), 32'(pix_dark_o));
               chk("pix_dummy", 32'(e.dm), 32'(pix_dummy_o));
            end
         end
      end
   end

   // row period from successive readout starts
   always @(negedge core_clk_i) begin
      cyc++;
      if (meas) begin
         fv_cnt += 32'(frame_valid_o === 1'b1);
         lv_cnt += 32'(line_valid_o === 1'b1);
      end
      if (meas && gate_rsel_o === 1'b1 && !rsel_q) begin
         chk("gate row", 32'(rises), 32'(gate_row_o));
         if (rises > 0)
            chk("row period", 32'(VCW + 2 + 1 + 19), 32'(cyc - last));
         rises++;
         last = cyc;
      end
      rsel_q = (gate_rsel_o === 1'b1);
   end

   initial begin
      #(25 * 40000);
      error_cnt++;
      summarize();
   end

   initial begin
      core_clk_i = 0; rst_b_i = 0; cap_wr_i = 0; cap_data_i = 8'h00; stream_wr_i = 0;
      stream_data_i = 8'h00; sync_i = 0; slow = 1; meas = 0; rsel_q = 0;
      vcw_i = 12'(VCW); shs_i = 8'h01; shr_i = 8'h01; vrd_i = 12'(VRD); cint_i = 12'h001;
      pix = 10'h001 + 10'({$random(seed)} % 1022);
      adc_data_i = pix;
      repeat (10) @(posedge core_clk_i);
      #1 chk("cap reset", 32'(CAP_CTRL_RST), 32'(cap_ctrl_o));
      chk("stream reset", 32'(STREAM_CTRL_RST), 32'(stream_ctrl_o));
      rst_b_i = 1;
      stream_wr_i = 1;
      stream_data_i = 8'h01 << STREAM_ENC_BIT;
      for (int f = 0; f < 2; f++)
         for (int r = 0; r <= VRD; r++)
            push_row(r, 1'b1);
      @(posedge core_clk_i) #1 stream_wr_i = 0;
      @(posedge core_clk_i) #1 chk("stream bit", 32'h1, 32'(stream_ctrl_o[STREAM_ENC_BIT]));
      chk("busy cont", 32'h1, 32'(busy_o));
      // words of the second frame have left, so it is under way: ask for single frame, taken at its end
      for (n = 0; n < 20000 && q.size() > 28; n++) @(posedge core_clk_i);
      #1 cap_wr_i = 1;
      cap_data_i = 8'h01 << CAP_MODE_BIT;
      @(posedge core_clk_i) #1 cap_wr_i = 0;
      @(posedge core_clk_i) #1 chk("cap bit", 32'h1, 32'(cap_ctrl_o[CAP_MODE_BIT]));
      for (n = 0; n < 20000 && busy_o !== 1'b0; n++) @(posedge core_clk_i);
      for (n = 0; n < 2000 && q.size() != 0; n++) @(posedge core_clk_i);
      chk("frames left", 32'h0, 32'(q.size()));
      #1 slow = 0;
      shs_i = 8'h02;
      repeat (40) @(posedge core_clk_i);
      #1 chk("idle no sync", 32'h0, 32'(busy_o));
      for (int r = 0; r <= VRD; r++)
         push_row(r, 1'b0);
      meas = 1;
      sync_i = 1;
      @(posedge core_clk_i) #1 sync_i = 0;
      chk("busy single", 32'h1, 32'(busy_o));
      for (n = 0; n < 5000 && busy_o !== 1'b0; n++) @(posedge core_clk_i);
      for (n = 0; n < 200 && q.size() != 0; n++) @(posedge core_clk_i);
      #1 chk("busy end", 32'h0, 32'(busy_o));
      chk("single left", 32'h0, 32'(q.size()));
      chk("single rows", 32'(VRD + 1), 32'(rises));
      chk("line valid", 32'(VCW * (VRD + 1)), 32'(lv_cnt));
      chk("frame valid", 32'((VRD + 1) * (VCW + 2 + 1 + 19)), 32'(fv_cnt));
      summarize();
   end
endmodule : tb

bind rsrs_row_sequencer rsrs_chk rsrs_chk_inst (.*);
`default_nettype wire
